/* File: uhps_defs.vh */
// Notes on behaviour
// RULE_01 - smart standby: request only when ports suspended and interconnect idle
// RULE_02 - software saves command, clears async bit 5 and periodic bit 4
// RULE_03 - status bits 15 and 14 show true schedule state; software polls
// RULE_04 - software suspends ports, waits about 3 ms, restores command
// RULE_05 - core master reaches interconnect through a bridge, singles and bursts
// RULE_06 - a single read after a write is never dropped under back-pressure
// RULE_07 - control message: descriptor write-back, then two single reads
// RULE_08 - software pads out payload remainder to at least 16 bytes
// RULE_09 - after a stall software resets the module and re-enumerates
// RULE_10 - three ports, each owned by exactly one controller, both may run
// RULE_11 - enhanced controller carries 480 Mbit/s over UTMI or ULPI
// RULE_12 - open controller carries 12 and 1.5 Mbit/s over serial
// RULE_13 - a UTMI-driven port is converted to transceiverless link signalling
// RULE_14 - software puts all ports in one mode once any uses ULPI
// RULE_15 - third port never takes ULPI mode; serial or link mode only
// RULE_16 - in ULPI mode the block sources the port clock to the PHY
// RULE_17 - ULPI ports carry high speed only; slow devices need a hub
// RULE_18 - standby request drops on resume and link logic returns defined
`ifndef UHPS_DEFS_VH
`define UHPS_DEFS_VH
`define UHPS_A_CMD      4'h0
`define UHPS_A_STS      4'h4
`define UHPS_A_PCFG     4'h8
`define UHPS_A_CTRL     4'hc
`define UHPS_B_RUN      0
`define UHPS_B_PER_EN   4
`define UHPS_B_ASYNC_EN 5
`define UHPS_B_PER_ST   14
`define UHPS_B_ASYNC_ST 15
`define UHPS_B_SBY      0
`define UHPS_B_BUSY     1
`define UHPS_B_SBEN     0
`define UHPS_M_SERIAL   2'h0
`define UHPS_M_ULPI     2'h1
`define UHPS_M_LINK     2'h2
`define UHPS_OWN_OPEN   1'b1
`define UHPS_CLK_DIV    4'h2
`define UHPS_WAKE_EDGES 4'h3
`define UHPS_DESC_OFS   32'h0000_0008
`endif

/* File: uhps_standby.v */
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uhps_defs.vh"
module uhps_standby #(
  parameter NPORT = 3,
  parameter DW    = 32,
  parameter AW    = 32
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [3:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  input  wire              core_valid,
  output wire              core_ready,
  input  wire              core_write,
  input  wire [3:0]        core_blen,
  input  wire [AW-1:0]     core_addr,
  input  wire [DW-1:0]     core_wdata,
  output reg               core_rvalid,
  output reg  [DW-1:0]     core_rdata,
  input  wire              ctrl_msg_start,
  input  wire [AW-1:0]     ctrl_desc_addr,
  input  wire [DW-1:0]     ctrl_desc_data,
  output wire              ic_valid,
  input  wire              ic_ready,
  output wire              ic_write,
  output wire [3:0]        ic_blen,
  output wire [AW-1:0]     ic_addr,
  output wire [DW-1:0]     ic_wdata,
  input  wire              ic_resp_valid,
  input  wire [DW-1:0]     ic_resp_data,
  input  wire              link_clk,
  input  wire              port_resume,
  output reg  [NPORT-1:0]  port_hs,
  output reg  [NPORT-1:0]  port_link_conv,
  output reg  [NPORT-1:0]  port_suspend,
  output reg               ulpi_clk_out,
  output reg               standby_req
);
  localparam BW = 1 + 4 + AW + DW;
  localparam S_ACT   = 4'h1;
  localparam S_DRAIN = 4'h2;
  localparam S_SBY   = 4'h4;
  localparam S_WAKE  = 4'h8;
  localparam C_IDLE  = 4'h1;
  localparam C_WB    = 4'h2;
  localparam C_RD0   = 4'h4;
  localparam C_RD1   = 4'h8;

  // legal mode for a port; third port never takes ulpi
  function [1:0] legal_mode;
    input integer idx;
    input [1:0]   m;
    begin
      if (m == `UHPS_M_ULPI && idx == 2) // see RULE_15
        legal_mode = `UHPS_M_SERIAL;
      else if (m == 2'h3)
        legal_mode = `UHPS_M_SERIAL;
      else
        legal_mode = m;
    end
  endfunction

  reg rst_m_ff, rst_s_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_ff <= 1'b0;
      rst_s_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_s_ff <= rst_m_ff;
    end
  end
  wire rs_n = rst_s_ff;

  // link clock and resume pin synchronisers
  reg [2:0] lclk_ff;
  reg [1:0] res_ff;
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      lclk_ff <= 3'h0;
      res_ff  <= 2'h0;
    end else begin
      lclk_ff <= {lclk_ff[1:0], link_clk};
      res_ff  <= {res_ff[0], port_resume};
    end
  end
  wire lclk_rise = lclk_ff[1] & ~lclk_ff[2];
  wire resume_s  = res_ff[1];

  reg [31:0]       cmd_ff;
  reg [2*NPORT-1:0] mode_ff;
  reg [NPORT-1:0]  owner_ff;
  reg              sben_ff;
  reg [NPORT-1:0]  susp_req_ff;
  reg              async_st_ff, per_st_ff;
  reg [3:0]        st_ff;
  reg [3:0]        wake_cnt_ff;
  reg [7:0]        outst_ff;

  // bridge buffer, two entries
  reg [BW-1:0] buf_mem [0:1];
  reg          wp_ff, rp_ff;
  reg [1:0]    cnt_ff;
  wire         buf_full  = (cnt_ff == 2'h2);
  wire         buf_empty = (cnt_ff == 2'h0);

  // control message sequencer
  reg [3:0]    cs_ff;
  reg [AW-1:0] caddr_ff;
  reg [DW-1:0] cdata_ff;
  wire         seq_busy = ~cs_ff[0];
  reg          in_valid;
  reg [BW-1:0] in_word;
  always @* begin
    in_valid = 1'b0;
    in_word  = {BW{1'b0}};
    case (cs_ff)
      C_IDLE: begin
        in_valid = core_valid;
        in_word  = {core_write, core_blen, core_addr, core_wdata};
      end
      C_WB: begin
        in_valid = 1'b1;
        in_word  = {1'b1, 4'h0, caddr_ff, cdata_ff}; // see RULE_07
      end
      C_RD0: begin
        in_valid = 1'b1;
        in_word  = {1'b0, 4'h0, caddr_ff + `UHPS_DESC_OFS,
                    {DW{1'b0}}};
      end
      C_RD1: begin
        in_valid = 1'b1;
        in_word  = {1'b0, 4'h0,
                    caddr_ff + `UHPS_DESC_OFS + 32'h4, {DW{1'b0}}};
      end
      default: begin
        in_valid = 1'b0;
        in_word  = {BW{1'b0}};
      end
    endcase
  end
  // new requests stop while draining toward standby
  wire gate_new = st_ff[0] | st_ff[3];
  // nothing is taken while the internal reset still holds the buffer
  assign core_ready = rs_n & ~buf_full & ~seq_busy & gate_new;
  wire in_take  = in_valid & ~buf_full & gate_new;
  assign ic_valid = ~buf_empty;
  wire out_take = ic_valid & ic_ready;
  assign {ic_write, ic_blen, ic_addr, ic_wdata} = buf_mem[rp_ff];

  // write holds in buffer until taken, so a following read never drops
  always @(posedge clk) begin
    if (in_take)
      buf_mem[wp_ff] <= in_word; // see RULE_05 see RULE_06
  end
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      wp_ff    <= 1'b0;
      rp_ff    <= 1'b0;
      cnt_ff   <= 2'h0;
      outst_ff <= 8'h00;
    end else begin
      if (in_take)
        wp_ff <= ~wp_ff;
      if (out_take)
        rp_ff <= ~rp_ff;
      cnt_ff   <= cnt_ff + {1'b0, in_take} - {1'b0, out_take};
      outst_ff <= outst_ff + {7'h00, out_take & ~ic_write}
                  - {7'h00, ic_resp_valid};
    end
  end

  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      cs_ff       <= C_IDLE;
      caddr_ff    <= {AW{1'b0}};
      cdata_ff    <= {DW{1'b0}};
      core_rvalid <= 1'b0;
      core_rdata  <= {DW{1'b0}};
    end else begin
      core_rvalid <= ic_resp_valid;
      if (ic_resp_valid)
        core_rdata <= ic_resp_data;
      case (cs_ff)
        C_IDLE: if (ctrl_msg_start && !(core_valid && core_ready)) begin
          cs_ff    <= C_WB;
          caddr_ff <= ctrl_desc_addr;
          cdata_ff <= ctrl_desc_data;
        end
        C_WB:  if (in_take) cs_ff <= C_RD0;
        C_RD0: if (in_take) cs_ff <= C_RD1;
        C_RD1: if (in_take) cs_ff <= C_IDLE;
        default: cs_ff <= C_IDLE;
      endcase
    end
  end

  wire ic_idle = buf_empty & (outst_ff == 8'h00);

  // register file
  integer k;
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      cmd_ff      <= 32'h0000_0000;
      mode_ff     <= {2*NPORT{1'b0}};
      owner_ff    <= {NPORT{1'b0}};
      sben_ff     <= 1'b0;
      susp_req_ff <= {NPORT{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `UHPS_A_CMD: cmd_ff <= reg_wdata;
        `UHPS_A_PCFG: begin
          for (k = 0; k < NPORT; k = k + 1) begin
            mode_ff[2*k +: 2] <= legal_mode(k, reg_wdata[2*k +: 2]);
            owner_ff[k]       <= reg_wdata[8+k]; // see RULE_10
          end
        end
        `UHPS_A_CTRL: begin
          sben_ff     <= reg_wdata[`UHPS_B_SBEN];
          susp_req_ff <= reg_wdata[4 +: NPORT];
        end
        default: sben_ff <= sben_ff;
      endcase
    end
  end

  // schedule state sets as soon as enable and run are set, clears only after traffic drains
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      async_st_ff <= 1'b0;
      per_st_ff   <= 1'b0;
    end else begin
      if (cmd_ff[`UHPS_B_ASYNC_EN] & cmd_ff[`UHPS_B_RUN])
        async_st_ff <= 1'b1;
      else if (ic_idle & ~seq_busy)
        async_st_ff <= 1'b0; // see RULE_03
      if (cmd_ff[`UHPS_B_PER_EN] & cmd_ff[`UHPS_B_RUN])
        per_st_ff <= 1'b1;
      else if (ic_idle & ~seq_busy)
        per_st_ff <= 1'b0; // see RULE_03
    end
  end

  // per-port speed, link conversion and suspend
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      wire is_ulpi = (mode_ff[2*g +: 2] == `UHPS_M_ULPI);
      wire is_link = (mode_ff[2*g +: 2] == `UHPS_M_LINK);
      always @(posedge clk or negedge rs_n) begin
        if (!rs_n) begin
          port_hs[g]        <= 1'b0;
          port_link_conv[g] <= 1'b0;
          port_suspend[g]   <= 1'b0;
        end else begin
          // ulpi ports run high speed only, owner ignored
          port_hs[g] <= is_ulpi | // see RULE_17
            (owner_ff[g] != `UHPS_OWN_OPEN); // see RULE_11 see RULE_12
          // either controller may own a converted port
          port_link_conv[g] <= is_link; // see RULE_13
          port_suspend[g]   <= susp_req_ff[g] & ~st_ff[3];
        end
      end
    end
  endgenerate

  // port clock sourced while any ulpi port is configured
  wire any_ulpi = (mode_ff[1:0] == `UHPS_M_ULPI) |
                  (mode_ff[3:2] == `UHPS_M_ULPI);
  reg [3:0] div_ff;
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      div_ff       <= 4'h0;
      ulpi_clk_out <= 1'b0;
    end else if (!any_ulpi) begin
      div_ff       <= 4'h0;
      ulpi_clk_out <= 1'b0;
    end else if (div_ff == `UHPS_CLK_DIV - 4'h1) begin
      div_ff       <= 4'h0;
      ulpi_clk_out <= ~ulpi_clk_out; // see RULE_16
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  // smart standby sequencer
  wire all_susp = &port_suspend;
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      st_ff       <= S_ACT;
      standby_req <= 1'b0;
      wake_cnt_ff <= 4'h0;
    end else begin
      case (st_ff)
        S_ACT: begin
          standby_req <= 1'b0;
          if (sben_ff && all_susp && !resume_s)
            st_ff <= S_DRAIN;
        end
        S_DRAIN: begin
          if (!sben_ff || !all_susp || resume_s) begin
            st_ff <= S_ACT;
          end else if (ic_idle && !seq_busy) begin
            st_ff       <= S_SBY;
            standby_req <= 1'b1; // see RULE_01
          end
        end
        S_SBY: begin
          if (resume_s || !sben_ff || !all_susp) begin
            st_ff       <= S_WAKE;
            standby_req <= 1'b0; // see RULE_18
            wake_cnt_ff <= 4'h0;
          end
        end
        S_WAKE: begin
          standby_req <= 1'b0;
          if (lclk_rise)
            wake_cnt_ff <= wake_cnt_ff + 4'h1;
          if (wake_cnt_ff == `UHPS_WAKE_EDGES)
            st_ff <= S_ACT; // see RULE_18
        end
        default: begin
          st_ff       <= S_ACT;
          standby_req <= 1'b0;
        end
      endcase
    end
  end

  // register read, data one cycle after strobe
  always @(posedge clk or negedge rs_n) begin
    if (!rs_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `UHPS_A_CMD: reg_rdata <= cmd_ff;
        `UHPS_A_STS: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[`UHPS_B_ASYNC_ST] <= async_st_ff;
          reg_rdata[`UHPS_B_PER_ST]   <= per_st_ff;
          reg_rdata[`UHPS_B_SBY]  <= standby_req;
          reg_rdata[`UHPS_B_BUSY] <= ~ic_idle;
        end
        `UHPS_A_PCFG: reg_rdata <= {21'h0, owner_ff, 2'h0, mode_ff};
        `UHPS_A_CTRL: reg_rdata <= {25'h0, port_suspend, 3'h0,
                                    sben_ff};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // uhps_standby
`default_nettype wire

/* File: uhps_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module uhps_chk #(
  parameter NPORT = 3
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             core_valid,
  input wire logic             core_ready,
  input wire logic [3:0]       core_blen,
  input wire logic             core_rvalid,
  input wire logic [31:0]      core_rdata,
  input wire logic             ic_valid,
  input wire logic             ic_ready,
  input wire logic [3:0]       ic_blen,
  input wire logic [31:0]      ic_addr,
  input wire logic             ic_resp_valid,
  input wire logic [31:0]      ic_resp_data,
  input wire logic             port_resume,
  input wire logic [NPORT-1:0] port_hs,
  input wire logic [NPORT-1:0] port_suspend,
  input wire logic             ulpi_clk_out,
  input wire logic             standby_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; core_valid && core_ready; endsequence
  sequence s_stall; ic_valid && !ic_ready; endsequence
  chk_sby_idle: assert property (
    $rose(standby_req) |-> !ic_valid && (&port_suspend))
    else $error("standby raised with traffic or awake ports");
  chk_sby_refuse: assert property (
    standby_req |-> !core_ready)
    else $error("request accepted during standby");
  chk_resume_drop: assert property (
    port_resume [*3] |-> ##[0:3] !standby_req)
    else $error("standby held through resume");
  chk_resp_fwd: assert property (
    ic_resp_valid |=> core_rvalid && core_rdata == $past(ic_resp_data))
    else $error("read response lost or altered");
  chk_resp_cause: assert property (
    core_rvalid |-> $past(ic_resp_valid))
    else $error("read response without cause");
  chk_ic_hold: assert property (
    s_stall |=> ic_valid && $stable(ic_addr))
    else $error("request changed under back-pressure");
  chk_take_fwd: assert property (
    s_take ##0 !ic_valid |=> ic_valid && ic_blen == $past(core_blen))
    else $error("accepted request not forwarded");
  chk_ulpi_hs: assert property (
    $rose(ulpi_clk_out) |-> port_hs[1:0] != 2'b00)
    else $error("port clock without high-speed port");
endmodule // uhps_chk

bind uhps_standby uhps_chk #(.NPORT(NPORT)) u_chk (
  .clk(clk), .rst_n(rst_n), .core_valid(core_valid),
  .core_ready(core_ready), .core_blen(core_blen),
  .core_rvalid(core_rvalid), .core_rdata(core_rdata),
  .ic_valid(ic_valid), .ic_ready(ic_ready), .ic_blen(ic_blen),
  .ic_addr(ic_addr), .ic_resp_valid(ic_resp_valid),
  .ic_resp_data(ic_resp_data), .port_resume(port_resume),
  .port_hs(port_hs), .port_suspend(port_suspend),
  .ulpi_clk_out(ulpi_clk_out), .standby_req(standby_req)
);
`default_nettype wire

/* File: uhps_ic_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uhps_ic_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        ic_valid,
  input  wire logic        ic_write,
  input  wire logic [31:0] ic_addr,
  output logic             ic_ready,
  output logic             ic_resp_valid,
  output logic [31:0]      ic_resp_data
);
  logic [31:0] rq[$];
  initial ic_resp_valid = 1'b0;
  initial ic_resp_data = 32'h0;
  // congestion from other initiators shows as stall
  assign ic_ready = !stall;
  always @(posedge clk) begin
    if (ic_valid && ic_ready && !ic_write)
      rq.push_back(ic_addr ^ 32'h5a5a_5a5a);
    if (rq.size() > 0 && !stall) begin
      ic_resp_valid <= 1'b1;
      ic_resp_data  <= rq.pop_front();
    end else begin
      ic_resp_valid <= 1'b0;
      // stale data must not look valid
      ic_resp_data  <= ~ic_resp_data;
    end
  end
endmodule // uhps_ic_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uhps_defs.vh"
module tb_top;
  logic        clk, link_clk, stall, ic_ready, ic_resp_valid;
  logic        rst_n = 0, port_resume = 0, hold = 0;
  logic        reg_wr = 0, reg_rd = 0, core_valid = 0, core_write = 0;
  logic        ctrl_msg_start = 0;
  logic [3:0]  reg_addr = 0, core_blen = 0, ic_blen;
  logic [31:0] reg_wdata = 0, core_addr = 0, core_wdata = 0;
  logic [31:0] ctrl_desc_addr = 0, ctrl_desc_data = 0;
  logic [31:0] reg_rdata, core_rdata, ic_addr, ic_wdata, ic_resp_data;
  logic        core_ready, core_rvalid, ic_valid, ic_write;
  logic        ulpi_clk_out, standby_req;
  logic [2:0]  port_hs, port_link_conv, port_suspend;
  logic [31:0] seed = 32'h0000_db09, v, sv, last_wd;
  logic [32:0] icq[$];
  logic [31:0] eq[$];
  logic [31:0] pcfg[4] = '{32'h715, 32'h72a, 32'h0, 32'h3f};
  logic [31:0] pexp[4] = '{32'h705, 32'h72a, 32'h0, 32'h0};
  logic [5:0]  pio[4] = '{6'o30, 6'o07, 6'o70, 6'o70};
  int          num_errors, cmp_count, n;

  uhps_standby u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_valid(core_valid), .core_ready(core_ready),
    .core_write(core_write), .core_blen(core_blen), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rvalid(core_rvalid),
    .core_rdata(core_rdata), .ctrl_msg_start(ctrl_msg_start),
    .ctrl_desc_addr(ctrl_desc_addr), .ctrl_desc_data(ctrl_desc_data),
    .ic_valid(ic_valid), .ic_ready(ic_ready), .ic_write(ic_write),
    .ic_blen(ic_blen), .ic_addr(ic_addr), .ic_wdata(ic_wdata),
    .ic_resp_valid(ic_resp_valid), .ic_resp_data(ic_resp_data),
    .link_clk(link_clk), .port_resume(port_resume), .port_hs(port_hs),
    .port_link_conv(port_link_conv), .port_suspend(port_suspend),
    .ulpi_clk_out(ulpi_clk_out), .standby_req(standby_req));
  uhps_ic_model u_ic (
    .clk(clk), .stall(stall), .ic_valid(ic_valid), .ic_write(ic_write),
    .ic_addr(ic_addr), .ic_ready(ic_ready),
    .ic_resp_valid(ic_resp_valid), .ic_resp_data(ic_resp_data));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    return a ^ 32'h5a5a_5a5a;
  endfunction
  task automatic cmp(input string nm, input logic [32:0] e, s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic core(input logic w, input logic [31:0] a, d,
                      input logic [3:0] bl);
    int k;
    k = 0;
    core_valid <= 1'b1;
    core_write <= w;
    core_addr <= a;
    core_wdata <= d;
    core_blen <= bl;
    do begin @(negedge clk); k++; end while (core_ready !== 1'b1 && k < 300);
    cmp("core_rdy", 1, core_ready);
    @(posedge clk);
    if (!w) eq.push_back(exp_rd(a));
    core_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitv(ref logic s, input logic e);
    int k;
    k = 0;
    while (s !== e && k < 400) begin @(posedge clk); #1; k++; end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin clk = 0; forever #10 clk = ~clk; end
  initial begin link_clk = 0; #7; forever #80 link_clk = ~link_clk; end
  initial begin #400000; num_errors++; stop_test(); end
  always @(posedge clk) stall <= hold | rnd() > 32'h8000_0000;
  always @(posedge clk) begin
    if (ic_valid === 1'b1 && ic_ready === 1'b1) begin
      icq.push_back({ic_write, ic_addr});
      if (ic_write === 1'b1) last_wd <= ic_wdata;
    end
    if (core_rvalid === 1'b1 && eq.size() > 0)
      cmp("rdata", eq.pop_front(), core_rdata);
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, v);
    cmp("unmapped", 0, v);
    for (int i = 0; i < 4; i++) begin
      wr(`UHPS_A_PCFG, pcfg[i]);
      rd(`UHPS_A_PCFG, v);
      cmp("pcfg", pexp[i], v);
      n = 0;
      repeat (8) begin @(posedge clk); n += ulpi_clk_out; end
      cmp("ulpi_clk", i == 0 ? 4 : 0, n);
      cmp("hs_link", pio[i], {port_hs, port_link_conv});
    end
    wr(`UHPS_A_CMD, 32'h31);
    rd(`UHPS_A_STS, v);
    cmp("sched_on", 2'b11, v[15:14]);
    rd(`UHPS_A_CMD, sv);
    cmp("cmd_save", 32'h31, sv);
    wr(`UHPS_A_CMD, 32'h01);
    n = 0;
    do begin rd(`UHPS_A_STS, v); n++; end while (v[15:14] !== 0 && n < 20);
    cmp("sched_off", 0, v[15:14]);
    hold <= 1'b1;
    core(1'b1, 32'h100, 32'h1, 4'h0);
    core(1'b0, 32'h104, 32'h0, 4'h0);
    wr(`UHPS_A_CTRL, 32'h71);
    repeat (20) @(posedge clk);
    cmp("sby_busy", 0, standby_req);
    hold <= 1'b0;
    waitv(standby_req, 1'b1);
    cmp("sby_on", 1, standby_req);
    cmp("susp", 3'h7, port_suspend);
    cmp("rd_kept", 0, eq.size());
    wr(`UHPS_A_CMD, sv);
    port_resume <= 1'b1;
    waitv(standby_req, 1'b0);
    cmp("sby_off", 0, standby_req);
    wr(`UHPS_A_CTRL, 32'h0);
    port_resume <= 1'b0;
    waitv(core_ready, 1'b1);
    cmp("awake", 1, core_ready);
    icq.delete();
    ctrl_desc_addr <= 32'h200;
    ctrl_desc_data <= 32'hd00d;
    eq.push_back(exp_rd(32'h200 + `UHPS_DESC_OFS));
    eq.push_back(exp_rd(32'h204 + `UHPS_DESC_OFS));
    ctrl_msg_start <= 1'b1;
    @(posedge clk);
    ctrl_msg_start <= 1'b0;
    repeat (40) @(posedge clk);
    cmp("n_ops", 3, icq.size());
    cmp("desc_wr", {1'b1, 32'h200}, icq[0]);
    cmp("cmd_rd0", {1'b0, 32'h200 + `UHPS_DESC_OFS}, icq[1]);
    cmp("cmd_rd1", {1'b0, 32'h204 + `UHPS_DESC_OFS}, icq[2]);
    cmp("desc_dat", 32'hd00d, last_wd);
    cmp("cmd_rsp", 0, eq.size());
    for (int i = 0; i < 60; i++) begin
      v = rnd();
      // writes go as bursts, never a short remainder
      core(v[0], {v[31:4], 4'h0}, rnd(),
           v[0] ? (v[7:4] | 4'h3) : 4'h0);
    end
    n = 0;
    while (eq.size() > 0 && n < 200) begin @(posedge clk); n++; end
    cmp("all_resp", 0, eq.size());
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`UHPS_A_CMD, v);
    cmp("rst_cmd", 0, v);
    cmp("rst_susp", 0, port_suspend);
    core(1'b0, 32'h300, 32'h0, 4'h0);
    n = 0;
    while (eq.size() > 0 && n < 200) begin @(posedge clk); n++; end
    cmp("re_enum", 0, eq.size());
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
